// ---- common/ca_defines.svh ----
`ifndef CA_DEFINES_SVH
`define CA_DEFINES_SVH

// register byte addresses on the bus
`define ADDR_MODE 8'h00
`define ADDR_CONTROL 8'h04
`define ADDR_TB_LOW 8'h08
`define ADDR_TB_HIGH 8'h0c
`define ADDR_MODMODE_BASE 8'h10
`define ADDR_CAP_BASE 8'h30
`define MODMODE_STRIDE 8'h04
`define CAP_STRIDE 8'h08
`define CAP_HIGH_OFFSET 8'h04

// structure
`define NUM_MODULES 5
`define WATCHDOG_MODULE 4
`define PIN_BASE 3
`define EXT_COUNT_BIT 2

// counter_array_mode fields
`define MODE_OVF_IRQ_EN 0
`define MODE_SRC_LSB 1
`define MODE_SRC_MSB 2
`define MODE_WDT_EN 6
`define MODE_IDLE_STOP 7
`define MODE_WRITE_MASK 8'hc7

// counter_array_control fields
`define CTRL_OVF_FLAG 7
`define CTRL_RUN 6

// module_mode_control fields
`define MM_IRQ_EN 0
`define MM_PWM 1
`define MM_TOGGLE 2
`define MM_MATCH 3
`define MM_CAP_FALL 4
`define MM_CAP_RISE 5
`define MM_COMP_EN 6
`define MM_WRITE_MASK 8'h7f

// reset values
`define MODE_RESET 8'h00
`define MODMODE_RESET 8'h00
`define CAP_RESET 8'h00
`define TB_RESET 16'h0000

// oscillator periods per count, by source code and clock mode
`define DIV_SLOW_6CLK 4'h6
`define DIV_SLOW_12CLK 4'hc
`define DIV_FAST_6CLK 4'h2
`define DIV_FAST_12CLK 4'h4

`endif

// ---- common/ca_pkg.sv ----
package ca_pkg;
  // time-base count source selection
  typedef enum logic [1:0] {
    SRC_OSC_SLOW = 2'b00,
    SRC_OSC_FAST = 2'b01,
    SRC_TIMER0 = 2'b10,
    SRC_EXT_PIN = 2'b11
  } count_source_type;
endpackage

// ---- hdl/cc_channel.sv ----
`timescale 1ns/100ps
`include "ca_defines.svh"

module cc_channel (
  input wire logic clk, // system clock
  input wire logic rst, // async reset, high
  input wire logic [7:0] mode, // module_mode_control
  input wire logic [15:0] timebase, // shared time base
  input wire logic fresh, // time base advanced by a count last edge
  input wire logic pin_in, // module pin level
  input wire logic wr_low, // software write, low byte
  input wire logic wr_high, // software write, high byte
  input wire logic [7:0] wdata, // software write data
  output logic [7:0] cap_low, // capture/compare low byte
  output logic [7:0] cap_high, // capture/compare high byte
  output logic match, // compare match pulse
  output logic event_hit, // flag-setting event pulse
  output logic pin_out // waveform output
);
  import ca_pkg::*;

  logic pin_prev;
  logic rise;
  logic fall;
  logic capture;
  logic pwm_mode;

  // comparator against the full 16-bit value
  assign match = mode[`MM_COMP_EN] & fresh &
                 ({cap_high, cap_low} == timebase); // RULE17
  // edge selection for capture
  assign rise = pin_in & ~pin_prev;
  assign fall = ~pin_in & pin_prev;
  assign capture = (rise & mode[`MM_CAP_RISE]) |
                   (fall & mode[`MM_CAP_FALL]); // RULE16
  assign event_hit = capture | (match & mode[`MM_MATCH]); // RULE15
  assign pwm_mode = mode[`MM_PWM] & mode[`MM_COMP_EN]; // RULE13

  // previous pin level for edge detection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_prev <= 1'b0;
    end else begin
      pin_prev <= pin_in;
    end
  end

  // low byte: capture, software, or duty reload at low-byte wrap
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cap_low <= `CAP_RESET;
    end else if (capture) begin
      cap_low <= timebase[7:0]; // RULE19 RULE18
    end else if (wr_low) begin
      cap_low <= wdata;
    end else if (pwm_mode && fresh && timebase[7:0] == 8'h00) begin
      cap_low <= cap_high; // RULE21
    end
  end

  // high byte: capture or software
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cap_high <= `CAP_RESET;
    end else if (capture) begin
      cap_high <= timebase[15:8]; // RULE19 RULE18
    end else if (wr_high) begin
      cap_high <= wdata;
    end
  end

  // waveform: pwm comparison or toggle on match
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_out <= 1'b0;
    end else if (pwm_mode) begin
      pin_out <= (timebase[7:0] >= cap_low); // RULE20
    end else if (match && mode[`MM_TOGGLE]) begin
      pin_out <= ~pin_out; // RULE14
    end
  end
endmodule

// ---- hdl/counter_array.sv ----
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`include "ca_defines.svh"

// Notes on behaviour
// RULE1 - one 16-bit time base, five modules
// RULE2 - module n uses port bit n+3
// RULE3 - code 00 counts every 6/12 clocks
// RULE4 - code 01 counts every 2/4 clocks
// RULE5 - code 10 timer0 overflow, 11 external pin
// RULE6 - idle stop bit halts during idle
// RULE7 - watchdog enable bit, module 4 only
// RULE8 - overflow sets flag, enable gates interrupt
// RULE9 - overflow flag cleared only by software
// RULE10 - run bit starts, clearing it stops
// RULE11 - module flags set by hardware, software clears
// RULE12 - mode bit 0 enables module interrupt
// RULE13 - mode bit 1 selects pwm mode
// RULE14 - mode bit 2 toggles pin on match
// RULE15 - mode bit 3 sets flag on match
// RULE16 - bits 4/5 capture falling/rising edges
// RULE17 - mode bit 6 enables the comparator
// RULE18 - two bytes hold capture or compare value
// RULE19 - capture copies time base into bytes
// RULE20 - pwm output low while below duty
// RULE21 - duty byte reloads at low-byte wrap
// RULE22 - watchdog match raises internal reset only
// RULE23 - time base increments and wraps to zero

module counter_array (
  input wire logic MCLK, // 200 MHz system clock
  input wire logic RST, // async reset, high
  input wire logic [7:0] PADDR, // apb byte address
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb access phase
  input wire logic PWRITE, // apb direction
  input wire logic [31:0] PWDATA, // apb write data
  output logic [31:0] PRDATA, // apb read data
  output logic PREADY, // apb ready
  output logic PSLVERR, // apb unmapped access
  input wire logic CLOCK_MODE_12, // 1: 12-clock mode
  input wire logic IDLE, // processor idle mode
  input wire logic TIMER0_OVERFLOW, // timer 0 overflow pulse
  input wire logic [7:0] PORT1_IN, // port 1 pin levels
  output logic [7:0] PORT1_OUT, // port 1 drive levels
  output logic [7:0] PORT1_OE, // port 1 drive enables
  output logic IRQ, // interrupt request
  output logic WATCHDOG_RESET // internal reset pulse
);
  import ca_pkg::*;

  localparam int NM = `NUM_MODULES;

  logic [7:0] counter_array_mode;
  logic run_bit;
  logic overflow_flag;
  logic [NM-1:0] module_event_flag;
  logic [15:0] timebase;
  logic [NM-1:0][7:0] module_mode_control;
  logic [NM-1:0][7:0] cap_low;
  logic [NM-1:0][7:0] cap_high;
  logic [NM-1:0] chan_match;
  logic [NM-1:0] chan_event;
  logic [NM-1:0] chan_pin;
  logic [3:0] prescale;
  logic [3:0] divisor;
  logic ext_prev;
  logic count_tick;
  logic counting;
  logic advance;
  logic tb_fresh;
  logic overflow_event;
  count_source_type source;

  logic access;
  logic wr;
  logic hit_mode;
  logic hit_ctrl;
  logic hit_tbl;
  logic hit_tbh;
  logic [NM-1:0] hit_mm;
  logic [NM-1:0] hit_capl;
  logic [NM-1:0] hit_caph;
  logic mapped;
  logic tb_wr;
  logic ctrl_wr;
  logic [7:0] read_value;
  logic [7:0] wbyte;

  assign source = count_source_type'(
    counter_array_mode[`MODE_SRC_MSB:`MODE_SRC_LSB]);
  assign access = PSEL & PENABLE;
  assign wr = access & PWRITE;
  assign wbyte = PWDATA[7:0];
  assign tb_wr = wr & (hit_tbl | hit_tbh);
  assign ctrl_wr = wr & hit_ctrl;

  // address decode
  always_comb begin
    hit_mode = 1'b0;
    hit_ctrl = 1'b0;
    hit_tbl = 1'b0;
    hit_tbh = 1'b0;
    if (PADDR == `ADDR_MODE) begin
      hit_mode = 1'b1;
    end else if (PADDR == `ADDR_CONTROL) begin
      hit_ctrl = 1'b1;
    end else if (PADDR == `ADDR_TB_LOW) begin
      hit_tbl = 1'b1;
    end else if (PADDR == `ADDR_TB_HIGH) begin
      hit_tbh = 1'b1;
    end
    for (int n = 0; n < NM; n++) begin
      hit_mm[n] = PADDR == (`ADDR_MODMODE_BASE +
                  8'(n) * `MODMODE_STRIDE);
      hit_capl[n] = PADDR == (`ADDR_CAP_BASE + 8'(n) * `CAP_STRIDE);
      hit_caph[n] = PADDR == (`ADDR_CAP_BASE + 8'(n) * `CAP_STRIDE +
                    `CAP_HIGH_OFFSET);
    end
    mapped = hit_mode | hit_ctrl | hit_tbl | hit_tbh | (|hit_mm) |
             (|hit_capl) | (|hit_caph);
  end

  // read multiplexer
  always_comb begin
    read_value = 8'h00;
    if (hit_mode) begin
      read_value = counter_array_mode;
    end else if (hit_ctrl) begin
      read_value = {overflow_flag, run_bit, 1'b0, module_event_flag};
    end else if (hit_tbl) begin
      read_value = timebase[7:0];
    end else if (hit_tbh) begin
      read_value = timebase[15:8];
    end
    for (int n = 0; n < NM; n++) begin
      if (hit_mm[n]) begin
        read_value = module_mode_control[n];
      end
      if (hit_capl[n]) begin
        read_value = cap_low[n];
      end
      if (hit_caph[n]) begin
        read_value = cap_high[n];
      end
    end
  end

  // zero-wait slave, error on unmapped address
  assign PREADY = 1'b1;
  assign PSLVERR = access & ~mapped;

  // read data captured in the setup cycle
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      PRDATA <= 32'h00000000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      PRDATA <= {24'h000000, read_value};
    end
  end

  // mode register
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      counter_array_mode <= `MODE_RESET;
    end else if (wr && hit_mode) begin
      counter_array_mode <= wbyte & `MODE_WRITE_MASK;
    end
  end

  // per-module mode registers
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      module_mode_control <= '0;
    end else begin
      for (int n = 0; n < NM; n++) begin
        if (wr && hit_mm[n]) begin
          module_mode_control[n] <= wbyte & `MM_WRITE_MASK;
        end
      end
    end
  end

  // run bit, written by software only
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      run_bit <= 1'b0;
    end else if (ctrl_wr) begin
      run_bit <= wbyte[`CTRL_RUN]; // RULE10
    end
  end

  // overflow flag: set wins over a clearing write of zero
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      overflow_flag <= 1'b0;
    end else begin
      overflow_flag <= overflow_event |
        (overflow_flag & ~(ctrl_wr & ~wbyte[`CTRL_OVF_FLAG])); // RULE8 RULE9
    end
  end

  // module flags: set by events, cleared by writing zero
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      module_event_flag <= '0;
    end else begin
      module_event_flag <= chan_event |
        (module_event_flag & ~({NM{ctrl_wr}} & ~wbyte[NM-1:0])); // RULE11
    end
  end

  // gating of flags onto the interrupt line
  always_comb begin
    IRQ = overflow_flag & counter_array_mode[`MODE_OVF_IRQ_EN]; // RULE8
    for (int n = 0; n < NM; n++) begin
      IRQ = IRQ | (module_event_flag[n] &
            module_mode_control[n][`MM_IRQ_EN]); // RULE12
    end
  end

  // divisor for the oscillator sources
  always_comb begin
    if (source == SRC_OSC_SLOW) begin
      divisor = CLOCK_MODE_12 ? `DIV_SLOW_12CLK : `DIV_SLOW_6CLK; // RULE3
    end else begin
      divisor = CLOCK_MODE_12 ? `DIV_FAST_12CLK : `DIV_FAST_6CLK; // RULE4
    end
  end

  // count source selection
  always_comb begin
    case (source)
      SRC_OSC_SLOW: count_tick = prescale >= divisor - 4'h1; // RULE3
      SRC_OSC_FAST: count_tick = prescale >= divisor - 4'h1; // RULE4
      SRC_TIMER0: count_tick = TIMER0_OVERFLOW; // RULE5
      SRC_EXT_PIN: count_tick = ext_prev & ~PORT1_IN[`EXT_COUNT_BIT]; // RULE5
      default: count_tick = 1'b0;
    endcase
  end

  assign counting = run_bit & ~(counter_array_mode[`MODE_IDLE_STOP] &
                    IDLE); // RULE6 RULE10
  assign advance = counting & count_tick & ~tb_wr;
  assign overflow_event = advance & (timebase == 16'hffff);

  // oscillator prescaler, held at zero while stopped
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      prescale <= 4'h0;
    end else if (!counting || prescale >= divisor - 4'h1) begin
      prescale <= 4'h0;
    end else begin
      prescale <= prescale + 4'h1;
    end
  end

  // external count pin history, falling edge counts
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= PORT1_IN[`EXT_COUNT_BIT];
    end
  end

  // shared time base, software load has priority
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      timebase <= `TB_RESET;
    end else if (wr && hit_tbl) begin
      timebase[7:0] <= wbyte;
    end else if (wr && hit_tbh) begin
      timebase[15:8] <= wbyte;
    end else if (advance) begin
      timebase <= timebase + 16'h0001; // RULE23 RULE1
    end
  end

  // marks the cycle after the time base advanced
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      tb_fresh <= 1'b0;
    end else begin
      tb_fresh <= advance;
    end
  end

  // five capture/compare modules on port bits 3 upward
  for (genvar n = 0; n < NM; n++) begin : g_mod
    cc_channel u_chan (
      .clk(MCLK),
      .rst(RST),
      .mode(module_mode_control[n]),
      .timebase(timebase),
      .fresh(tb_fresh),
      .pin_in(PORT1_IN[`PIN_BASE + n]), // RULE2
      .wr_low(wr & hit_capl[n]),
      .wr_high(wr & hit_caph[n]),
      .wdata(wbyte),
      .cap_low(cap_low[n]),
      .cap_high(cap_high[n]),
      .match(chan_match[n]),
      .event_hit(chan_event[n]),
      .pin_out(chan_pin[n])
    );
    assign PORT1_OUT[`PIN_BASE + n] = chan_pin[n]; // RULE2
    assign PORT1_OE[`PIN_BASE + n] = module_mode_control[n][`MM_COMP_EN] &
      (module_mode_control[n][`MM_TOGGLE] |
       module_mode_control[n][`MM_PWM]);
  end
  assign PORT1_OUT[`PIN_BASE-1:0] = '0;
  assign PORT1_OE[`PIN_BASE-1:0] = '0;

  // watchdog on module 4 only, internal pulse
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      WATCHDOG_RESET <= 1'b0;
    end else begin
      WATCHDOG_RESET <= counter_array_mode[`MODE_WDT_EN] &
                        chan_match[`WATCHDOG_MODULE]; // RULE7 RULE22
    end
  end

  // helper: cycles since last count with unchanged settings
  logic [3:0] gap;
  logic gap_ok;
  logic [2:0] cfg_prev;
  logic pin_last0;
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      gap <= 4'h0;
      gap_ok <= 1'b0;
      cfg_prev <= 3'h0;
      pin_last0 <= 1'b0;
    end else begin
      cfg_prev <= {source, CLOCK_MODE_12};
      pin_last0 <= PORT1_IN[`PIN_BASE];
      if (advance) begin
        gap <= 4'h0;
        gap_ok <= 1'b1;
      end else begin
        if (gap != 4'hf) begin
          gap <= gap + 4'h1;
        end
        if (!counting || tb_wr || cfg_prev != {source, CLOCK_MODE_12}) begin
          gap_ok <= 1'b0;
        end
      end
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  a_slow_rate: assert property ( // RULE3
    advance && gap_ok && source == SRC_OSC_SLOW &&
    cfg_prev == {source, CLOCK_MODE_12}
    |-> gap == (CLOCK_MODE_12 ? 4'hb : 4'h5))
    else $error("slow source count spacing wrong");

  a_fast_rate: assert property ( // RULE4
    advance && gap_ok && source == SRC_OSC_FAST &&
    cfg_prev == {source, CLOCK_MODE_12}
    |-> gap == (CLOCK_MODE_12 ? 4'h3 : 4'h1))
    else $error("fast source count spacing wrong");

  a_timer0_count: assert property ( // RULE5
    source == SRC_TIMER0 && counting && TIMER0_OVERFLOW && !tb_wr
    |=> timebase == $past(timebase) + 16'h0001)
    else $error("timer 0 overflow did not count");

  a_idle_halt: assert property ( // RULE6
    counter_array_mode[`MODE_IDLE_STOP] && IDLE && !tb_wr
    |=> $stable(timebase))
    else $error("time base moved during idle stop");

  a_run_stop: assert property ( // RULE10
    !run_bit && !tb_wr |=> $stable(timebase))
    else $error("time base moved while stopped");

  a_overflow_set: assert property ( // RULE8
    advance && timebase == 16'hffff
    |=> overflow_flag && timebase == 16'h0000)
    else $error("overflow did not set flag and wrap");

  a_overflow_hold: assert property ( // RULE9
    overflow_flag && !(ctrl_wr && !wbyte[`CTRL_OVF_FLAG])
    |=> overflow_flag)
    else $error("overflow flag cleared without software");

  a_event_flag: assert property ( // RULE11
    |chan_event |=> (module_event_flag & $past(chan_event)) ==
    $past(chan_event))
    else $error("module event did not set its flag");

  a_irq_masked: assert property ( // RULE12
    !overflow_flag && module_event_flag[0] &&
    !module_mode_control[0][`MM_IRQ_EN] &&
    (module_event_flag[NM-1:1] == '0) |-> !IRQ)
    else $error("masked module flag raised interrupt");

  a_watchdog_fire: assert property ( // RULE22
    counter_array_mode[`MODE_WDT_EN] && chan_match[`WATCHDOG_MODULE]
    |=> WATCHDOG_RESET ##1 !WATCHDOG_RESET || $past(chan_match[4]))
    else $error("watchdog match gave no reset pulse");

  a_toggle_pin: assert property ( // RULE14
    chan_match[0] && module_mode_control[0][`MM_TOGGLE] &&
    !module_mode_control[0][`MM_PWM]
    |=> PORT1_OUT[`PIN_BASE] != $past(PORT1_OUT[`PIN_BASE]))
    else $error("match did not toggle module 0 pin");

  a_capture_rise: assert property ( // RULE19
    module_mode_control[0][`MM_CAP_RISE] && PORT1_IN[`PIN_BASE] &&
    !pin_last0 |=> {cap_high[0], cap_low[0]} == $past(timebase))
    else $error("rising edge capture value wrong");
endmodule

// ---- bench/pin_model.sv ----
`timescale 1ns/100ps

// far side of port 1: pins the block leaves free follow the bench
module pin_model (
  input wire logic [7:0] oe, // block drive enables
  input wire logic [7:0] out, // block drive levels
  input wire logic [7:0] drv, // levels wanted by the bench
  output logic [7:0] pin // resolved pin levels
);
  // a driven pin shows the block, a free pin the bench
  always_comb pin = (oe & out) | (~oe & drv);
endmodule

// ---- bench/tb_top.sv ----
`timescale 1ns/100ps
`include "ca_defines.svh"

module tb_top;
  import ca_pkg::*;
  logic MCLK = 1'b0;
  logic RST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic PREADY;
  logic PSLVERR;
  logic CLOCK_MODE_12 = 1'b0;
  logic IDLE = 1'b0;
  logic TIMER0_OVERFLOW = 1'b0;
  logic [7:0] drv = 8'h00;
  logic [7:0] pins;
  logic [7:0] PORT1_OUT;
  logic [7:0] PORT1_OE;
  logic IRQ;
  logic WATCHDOG_RESET;
  logic slv;
  logic [31:0] rdat;
  integer err_total = 0;
  integer n_tests = 0;
  integer cyc = 0;
  integer wd_n = 0;
  integer seed = 32'hf828;

  counter_array counter_array_i (.MCLK(MCLK), .RST(RST), .PADDR(PADDR),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .CLOCK_MODE_12(CLOCK_MODE_12), .IDLE(IDLE),
    .TIMER0_OVERFLOW(TIMER0_OVERFLOW), .PORT1_IN(pins),
    .PORT1_OUT(PORT1_OUT), .PORT1_OE(PORT1_OE), .IRQ(IRQ),
    .WATCHDOG_RESET(WATCHDOG_RESET));
  pin_model pin_model_i (.oe(PORT1_OE), .out(PORT1_OUT), .drv(drv),
    .pin(pins));

  // clock
  always #2.5 MCLK = ~MCLK;

  // cycle ceiling and tally of watchdog pulses
  always @(posedge MCLK) begin
    cyc = cyc + 1;
    if (WATCHDOG_RESET === 1'b1) wd_n = wd_n + 1;
    if (cyc == 40000) begin
      err_total = err_total + 1;
      end_sim;
    end
  end

  task chk(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // one apb transfer, held until pready is seen high
  task xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge MCLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= {24'h0, d};
    @(posedge MCLK);
    PENABLE <= 1'b1;
    @(posedge MCLK);
    while (PREADY !== 1'b1) @(posedge MCLK);
    rdat = PRDATA;
    slv = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d);
  endtask

  task rd(input logic [7:0] a);
    xfer(a, 1'b0, 8'h00);
  endtask

  task settb(input logic [15:0] v);
    wr(`ADDR_TB_LOW, v[7:0]);
    wr(`ADDR_TB_HIGH, v[15:8]);
  endtask

  // count events: one-cycle timer 0 pulses or count pin falling edges
  task pulse(input int k, input bit ext);
    repeat (k) begin
      @(posedge MCLK);
      if (ext) drv[`EXT_COUNT_BIT] <= 1'b1;
      else TIMER0_OVERFLOW <= 1'b1;
      @(posedge MCLK);
      TIMER0_OVERFLOW <= 1'b0;
      @(posedge MCLK);
      drv[`EXT_COUNT_BIT] <= 1'b0;
    end
    repeat (4) @(posedge MCLK);
  endtask

  // low-byte advance between two reads sixty cycles apart
  task rate(output logic [7:0] dl);
    logic [7:0] a;
    rd(`ADDR_TB_LOW);
    a = rdat[7:0];
    repeat (57) @(posedge MCLK);
    rd(`ADDR_TB_LOW);
    dl = rdat[7:0] - a;
  endtask

  function automatic logic [7:0] per60(input bit fast, input bit m12);
    per60 = fast ? (m12 ? 8'd15 : 8'd30) : (m12 ? 8'd5 : 8'd10);
  endfunction

  // a falling-edge capture, when enabled, comes last and wins
  function automatic logic [15:0] cap_exp(input logic [7:0] m,
    input logic [15:0] v1, input logic [15:0] v2);
    cap_exp = m[`MM_CAP_FALL] ? v2 : v1;
  endfunction

  // main sequence
  initial begin
    logic [7:0] d;
    logic [7:0] m;
    logic [15:0] v1;
    logic [15:0] v2;
    logic [31:0] r;
    int hi;
    repeat (16) @(posedge MCLK);
    RST <= 1'b0;
    rd(`ADDR_MODE);
    chk("mode reset", rdat, 32'h0);
    chk("mapped err", slv, 1'b0);
    rd(`ADDR_CONTROL);
    chk("control reset", rdat, 32'h0);
    rd(8'hfc);
    chk("unmapped data", rdat, 32'h0);
    chk("unmapped err", slv, 1'b1);
    // oscillator rates in both clock modes
    wr(`ADDR_CONTROL, 8'h40);
    for (int i = 0; i < 4; i++) begin
      CLOCK_MODE_12 <= i[1];
      wr(`ADDR_MODE, {6'h0, i[0], 1'b0});
      rate(d);
      chk("rate", d, per60(i[0], i[1]));
    end
    CLOCK_MODE_12 <= 1'b0;
    // timer 0 and external count sources
    for (int s = 0; s < 2; s++) begin
      wr(`ADDR_MODE, s ? 8'h06 : 8'h04);
      rd(`ADDR_TB_LOW);
      d = rdat[7:0];
      hi = 1 + ($random(seed) & 7);
      pulse(hi, s[0]);
      rd(`ADDR_TB_LOW);
      chk("source count", 8'(rdat[7:0] - d), hi);
    end
    // idle stop and run bit
    IDLE <= 1'b1;
    wr(`ADDR_MODE, 8'h82);
    rate(d);
    chk("idle stopped", d, 8'd0);
    wr(`ADDR_MODE, 8'h02);
    rate(d);
    chk("idle running", d, 8'd30);
    IDLE <= 1'b0;
    wr(`ADDR_CONTROL, 8'h00);
    rate(d);
    chk("run cleared", d, 8'd0);
    // overflow flag, its interrupt gate and software clear
    wr(`ADDR_CONTROL, 8'h40);
    settb(16'hfff0);
    repeat (60) @(posedge MCLK);
    rd(`ADDR_TB_HIGH);
    chk("wrap high", rdat, 32'h0);
    rd(`ADDR_CONTROL);
    chk("ovf flag", rdat, 32'hc0);
    chk("ovf irq off", IRQ, 1'b0);
    wr(`ADDR_MODE, 8'h03);
    @(posedge MCLK);
    chk("ovf irq on", IRQ, 1'b1);
    repeat (100) @(posedge MCLK);
    rd(`ADDR_CONTROL);
    chk("ovf kept", rdat, 32'hc0);
    wr(`ADDR_CONTROL, 8'h40);
    rd(`ADDR_CONTROL);
    chk("ovf cleared", rdat, 32'h40);
    wr(`ADDR_MODE, 8'h04);
    // capture on every module, random edge choice on modules 2 to 4
    for (int n = 0; n < 5; n++) begin
      r = $random(seed);
      m = {2'b00, (r[1:0] == 2'b00) ? 2'b11 : r[1:0], 3'b000, r[2]};
      if (n == 0) m = 8'h30; // corner: both edges, interrupt masked
      if (n == 1) m = 8'h21; // corner: rising edge, interrupt on
      v1 = $random(seed);
      v2 = $random(seed);
      wr(`ADDR_MODMODE_BASE + 8'(4 * n), m);
      settb(v1);
      drv[n + 3] <= 1'b1;
      repeat (4) @(posedge MCLK);
      settb(v2);
      drv[n + 3] <= 1'b0;
      repeat (4) @(posedge MCLK);
      v1 = cap_exp(m, v1, v2);
      rd(`ADDR_CAP_BASE + 8'(8 * n));
      chk("cap low", rdat, v1[7:0]);
      rd(`ADDR_CAP_BASE + 8'(8 * n) + `CAP_HIGH_OFFSET);
      chk("cap high", rdat, v1[15:8]);
      rd(`ADDR_CONTROL);
      chk("cap flag", rdat, 32'h40 | (32'h1 << n));
      chk("cap irq", IRQ, m[0]);
      wr(`ADDR_CONTROL, 8'h40);
      @(posedge MCLK);
      chk("cap irq clear", IRQ, 1'b0);
      wr(`ADDR_MODMODE_BASE + 8'(4 * n), 8'h00);
    end
    // pwm duty on module 0
    d = $random(seed);
    wr(`ADDR_MODE, 8'h02);
    wr(`ADDR_CAP_BASE + `CAP_HIGH_OFFSET, d);
    wr(`ADDR_MODMODE_BASE, 8'h42);
    repeat (1100) @(posedge MCLK);
    hi = 0;
    repeat (512) begin
      @(posedge MCLK);
      hi = hi + int'(PORT1_OUT[3] === 1'b1);
    end
    chk("pwm high", hi, (256 - d) * 2);
    chk("pwm drive", PORT1_OE[3], 1'b1);
    wr(`ADDR_MODMODE_BASE, 8'h00);
    // match toggle on every module, watchdog armed throughout
    wr(`ADDR_MODE, 8'h44);
    for (int n = 0; n < 5; n++) begin
      v1 = $random(seed);
      wr(`ADDR_CAP_BASE + 8'(8 * n), v1[7:0]);
      wr(`ADDR_CAP_BASE + 8'(8 * n) + `CAP_HIGH_OFFSET, v1[15:8]);
      wr(`ADDR_MODMODE_BASE + 8'(4 * n), 8'h4c);
      settb(v1 - 16'h1);
      r[0] = PORT1_OUT[n + 3];
      pulse(1, 1'b0);
      chk("watchdog", wd_n, n == 4);
      chk("pin drive", PORT1_OE, 8'h1 << (n + 3));
      chk("toggle", PORT1_OUT[n + 3], !r[0]);
      rd(`ADDR_CONTROL);
      chk("match flag", rdat, 32'h40 | (32'h1 << n));
      pulse(1, 1'b0);
      chk("no toggle", PORT1_OUT[n + 3], !r[0]);
      wr(`ADDR_CONTROL, 8'h40);
      wr(`ADDR_MODMODE_BASE + 8'(4 * n), 8'h00);
    end
    end_sim;
  end
endmodule
